// ---- src/dsw_top.sv ----
// Purpose: Serial write front end of a single-channel voltage-output DAC.
// Assumes: The controller keeps frame sync low for at least a word of clocks.
// Notes: The word crosses to the system clock by a toggle handshake.
`timescale 1ns/1ns
`default_nettype none
module dsw_top #(
  parameter int WORD_W = dsw_pkg::WORD_BITS
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic frame_sync_n_i,
  input wire logic sdata_i,
  output logic [WORD_W-1:0] dac_word_o,
  output logic dac_update_o
);
  localparam int CNT_W = $clog2(WORD_W + 1);

  if (WORD_W < 2) begin : g_check
    $error("WORD_W must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side, on falling serial clock edges.

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic toggle;
  } dsw_link_type;

  dsw_link_type lk_reg;
  dsw_link_type lk_next;
  logic [CNT_W-1:0] bit_count;
  logic [WORD_W-1:0] shift_bits;
  logic frame_clear;

  assign frame_clear = reset_i | frame_sync_n_i;

  dsw_frame_rx #(
    .WORD_W(WORD_W),
    .CNT_W(CNT_W)
  ) u_frame_rx (
    .sclk_i(sclk_i),
    .frame_clear_i(frame_clear),
    .sdata_i(sdata_i),
    .count_o(bit_count),
    .shift_o(shift_bits)
  );

  always_comb begin
    lk_next = lk_reg;
    // Only a frame that reaches its last clock is handed over.
    if (!frame_sync_n_i && bit_count == CNT_W'(WORD_W - 1)) begin
      lk_next.word = {shift_bits[WORD_W-2:0], sdata_i};
      lk_next.toggle = ~lk_reg.toggle;
    end
  end

  always_ff @(negedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System side: toggle synchroniser and DAC register.

  typedef struct packed {
    logic [dsw_pkg::SYNC_STAGES-1:0] tsync;
    logic tseen;
    logic [WORD_W-1:0] dac;
    logic update;
  } dsw_sys_type;

  dsw_sys_type sy_reg;
  dsw_sys_type sy_next;

  always_comb begin
    sy_next = sy_reg;
    sy_next.tsync = {sy_reg.tsync[0], lk_reg.toggle};
    sy_next.tseen = sy_reg.tsync[1];
    sy_next.update = 1'b0;
    // The held word is stable for a whole frame after its toggle.
    if (sy_reg.tsync[1] != sy_reg.tseen) begin
      sy_next.dac = lk_reg.word;
      sy_next.update = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sy_reg <= '0;
      sy_reg.dac <= WORD_W'(dsw_pkg::DAC_RESET_WORD);
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign dac_word_o = sy_reg.dac;
  assign dac_update_o = sy_reg.update;
endmodule // dsw_top
`default_nettype wire

// ---- src/dsw_pkg.sv ----
// Purpose: Shared constants of the serial write front end.
// Assumes: Frames are word-long and MSB-first shifting is used.
// Notes: Timing figures live in the link; only the word width, reset word and synchroniser stage count are set here.
package dsw_pkg;
  localparam int WORD_BITS = 16;
  localparam logic [15:0] DAC_RESET_WORD = 16'h0000;
  localparam int SYNC_STAGES = 2;
endpackage

// ---- src/dsw_frame_rx.sv ----
// Purpose: Serial shift register and bit counter of one write frame.
// Assumes: Frame sync high clears the frame at once, without a clock.
// Notes: Runs on falling edges of the link clock.
`timescale 1ns/1ns
`default_nettype none
module dsw_frame_rx #(
  parameter int WORD_W = dsw_pkg::WORD_BITS,
  parameter int CNT_W = $clog2(WORD_W + 1)
) (
  input wire logic sclk_i,
  input wire logic frame_clear_i,
  input wire logic sdata_i,
  output logic [CNT_W-1:0] count_o,
  output logic [WORD_W-1:0] shift_o
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [WORD_W-1:0] shift;
  } dsw_rx_type;

  dsw_rx_type st_reg;
  dsw_rx_type st_next;

  always_comb begin
    st_next = st_reg;
    // Bits past the last are ignored until the next frame.
    if (st_reg.count < CNT_W'(WORD_W)) begin
      st_next.shift = {st_reg.shift[WORD_W-2:0], sdata_i};
      st_next.count = st_reg.count + CNT_W'(1);
    end
  end

  // A high frame sync holds the frame cleared and discards it.
  always_ff @(negedge sclk_i or posedge frame_clear_i) begin
    if (frame_clear_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count_o = st_reg.count;
  assign shift_o = st_reg.shift;
endmodule // dsw_frame_rx
`default_nettype wire

// ---- test/dsw_monitor.sv ----
// Purpose: port checker. Assumes: mclk domain. Notes: bound to top.
`timescale 1ns/1ns
`default_nettype none
module dsw_monitor #(parameter int WORD_W = 16) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic frame_sync_n_i,
  input wire logic [WORD_W-1:0] dac_word_o,
  input wire logic dac_update_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  AST_HOLD: assert property ($changed(dac_word_o) |-> dac_update_o)
    else $error("word moved alone");
  AST_PULSE: assert property (dac_update_o |=> !dac_update_o)
    else $error("long pulse");
  AST_INFRAME: assert property (dac_update_o |-> !$past(frame_sync_n_i, 4))
    else $error("update off frame");
  AST_IDLE: assert property (frame_sync_n_i [*8] |-> !dac_update_o)
    else $error("update when idle");
  AST_ZERO: assert property ($fell(reset_i) |-> dac_word_o == '0)
    else $error("word not zero");
  AST_SETTLE: assert property (dac_update_o |=> $stable(dac_word_o))
    else $error("word moved after update");
  cover property (dac_update_o);
  cover property ($rose(frame_sync_n_i));
  cover property ($fell(reset_i));
endmodule // dsw_monitor
bind dsw_top dsw_monitor #(.WORD_W(WORD_W)) mon_u (.mclk_i, .reset_i,
  .frame_sync_n_i, .dac_word_o, .dac_update_o);
`default_nettype wire

// ---- test/dsw_host_model.sv ----
// Purpose: serial master. Assumes: idle clock high. Notes: 48 ns link.
`timescale 1ns/1ns
`default_nettype none
module dsw_host_model (
  output logic sclk_o,
  output logic sync_n_o,
  output logic sdata_o
);
  initial begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    sdata_o = 1'b0;
  end
  // Sends n bits of w from the top; the clock stands still between frames.
  task automatic send(input logic [19:0] w, input int n);
    #5 sync_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdata_o = w[19-i];
      #24 sclk_o = 1'b0;
      #24 sclk_o = 1'b1;
    end
    #24 sync_n_o = 1'b1;
    sdata_o = ~sdata_o;
    #48;
  endtask
  // Clocks the link n times with frame sync held high.
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      #24 sclk_o = 1'b0;
      #24 sclk_o = 1'b1;
    end
  endtask
endmodule // dsw_host_model
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: bench. Assumes: host model drives link. Notes: no random.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk_i, reset_i, sclk, sync_n, sdata, upd;
  logic [15:0] word;
  int error_cnt, checked, ups;
  dsw_top dut_u (.mclk_i, .reset_i, .sclk_i(sclk), .frame_sync_n_i(sync_n),
    .sdata_i(sdata), .dac_word_o(word), .dac_update_o(upd));
  dsw_host_model host_u (.sclk_o(sclk), .sync_n_o(sync_n), .sdata_o(sdata));
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) if (upd === 1'b1) ups++;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [19:0] w, input int n,
    input logic [15:0] e, input int u);
    ups = 0;
    host_u.send(w, n);
    repeat (8) @(posedge mclk_i);
    cmp(word, e);
    cmp(16'(ups), 16'(u));
  endtask
  task automatic t_reset();
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    cmp(word, 16'h0000);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    reset_i = 1'b1;
    error_cnt = 0;
    checked = 0;
    ups = 0;
    t_reset();
    run({16'hA5C3, 4'h0}, 16, 16'hA5C3, 1);
    run(20'h5A3CF, 15, 16'hA5C3, 0);
    host_u.stray(5);
    run({16'h0F1E, 4'h0}, 16, 16'h0F1E, 1);
    run({16'h3C96, 4'hF}, 20, 16'h3C96, 1);
    t_reset();
    run({16'h1234, 4'h0}, 16, 16'h1234, 1);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
